//--- pcseq_defines.svh
// Constants for the program counter sequencer.
`ifndef PCSEQ_DEFINES_SVH
`define PCSEQ_DEFINES_SVH
`define PCSEQ_CNT_W        13
`define PCSEQ_ADDR_W       14
`define PCSEQ_WORD_W       16
`define PCSEQ_PROG_LAST    14'h2fff
`define PCSEQ_CHAR_FIRST   14'h3000
`define PCSEQ_CHAR_VLAST   14'h3fef
`define PCSEQ_CHAR_RLAST   15'h4fdf
`define PCSEQ_RESET_PC     13'h0000
`define PCSEQ_RESET_SEG    1'h0
`define PCSEQ_PAGE_HI      12
`define PCSEQ_PAGE_LO      11
`define PCSEQ_SYSTEM_CALL_INSTRUCTION_SEG   1'h1
`define PCSEQ_SYSTEM_CALL_INSTRUCTION_BLKLO 4
`define PCSEQ_CHAR_SPAN    2'h2
`endif

//--- pcseq_pkg.sv
// Types shared by the program counter sequencer files.
package pcseq_pkg;
   // Operation requested by the decode logic for the current instruction.
   typedef enum logic [2:0] {
      PCSEQ_OP_SEQ,
      PCSEQ_OP_BR_DIRECT,
      PCSEQ_OP_CALL_DIRECT,
      PCSEQ_OP_JUMP_INDIRECT,
      PCSEQ_OP_SYSTEM_CALL_INSTRUCTION,
      PCSEQ_OP_TABLE,
      PCSEQ_OP_RETURN
   } pcseq_op_t;
   typedef enum {
      PCSEQ_ST_RUN,
      PCSEQ_ST_TABLE_FETCH,
      PCSEQ_ST_TABLE_DELIVER
   } pcseq_state_t;
endpackage : pcseq_pkg

//--- pcseq_ce_edge.sv
// Level and rising-edge tracker for the operation-select input.
`include "pcseq_defines.svh"
module pcseq_ce_edge (
   input  wire logic clock,     // System clock.
   input  wire logic rst,       // Asynchronous reset, active high.
   input  wire logic level_in,  // Operation-select level, synchronous.
   input  wire logic align,     // Timer carry alignment strobe.
   output logic      enable,    // Registered copy of the level.
   output logic      reset_req  // One-cycle reset request.
);
   logic prev;
   logic pending;

   // Remember the last level so a rise can be seen.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev   <= 1'b0;
         enable <= 1'b0;
      end else begin
         prev   <= level_in;
         enable <= level_in;
      end
   end

   // A rise is held until the timer carry so reset lines up with it.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pending   <= 1'b0;
         reset_req <= 1'b0;
      end else begin
         reset_req <= 1'b0;
         if (pending && align) begin
            // A fresh rise in the same cycle must not be lost, so the
            // set wins over the clear here.
            pending   <= level_in && !prev;
            reset_req <= 1'b1;
         end else if (level_in && !prev) begin
            pending <= 1'b1;
         end
      end
   end
endmodule : pcseq_ce_edge

//--- pcseq_sequencer.sv
// Program counter, segment select and table-read sequencing.
//
// Notes on behaviour
// - Program words live at 0000H to 2FFFH.
// - 3000H to 4FDFH is character storage only.
// - Each instruction is one 16-bit word.
// - Table read puts a program word in buffer.
// - Video pattern addresses map onto character storage.
// - Counter is 13 bits plus segment bit.
// - Page is decoded from counter bits 11, 12.
// - System call loads the segment select bit.
// - Operation-select high enables synthesizer and display.
// - Operation-select rise resets, aligned to timer carry.
// - Power-on reset restarts at address zero.
// - Counter wraps inside its segment, no carry.
// - Both resets clear every counter bit.
`include "pcseq_defines.svh"
module pcseq_sequencer
   import pcseq_pkg::*;
#(
   parameter int CNT_W  = `PCSEQ_CNT_W,
   parameter int WORD_W = `PCSEQ_WORD_W
) (
   input  wire logic                  clock,          // System clock.
   input  wire logic                  rst,            // Power-on reset.
   input  wire logic                  op_select,      // Operation-select level.
   input  wire logic                  timer_carry,    // Interval timer carry.
   input  wire logic                  instr_valid,    // Instruction executes.
   input  wire pcseq_op_t             instr_op,       // Decoded operation.
   input  wire logic [CNT_W-1:0]      instr_addr,     // Direct operand.
   input  wire logic [6:0]            system_call_instruction_entry,   // System call entry.
   input  wire logic [CNT_W:0]        addr_reg,       // Address register.
   input  wire logic [CNT_W:0]        return_addr,    // Popped return address.
   input  wire logic [11:0]           video_pattern,  // Video pattern address.
   input  wire logic                  pattern_req,    // Pattern fetch request.
   input  wire logic [WORD_W-1:0]     prog_rdata,     // Program memory word.
   output logic [CNT_W:0]             prog_addr,      // Program memory address.
   output logic                       prog_rd,        // Program read strobe.
   output logic                       prog_addr_bad,  // Address outside store.
   output logic [WORD_W-1:0]          instr_word,     // Fetched instruction.
   output logic [1:0]                 page,           // Current page.
   output logic                       segment_select_bit, // Segment bit.
   output logic [CNT_W-1:0]           pc_count,       // Counter value.
   output logic [WORD_W-1:0]          data_buffer,    // Table read result.
   output logic                       data_buffer_vld, // Table word pulse.
   output logic                       busy,           // Counter is frozen.
   output logic [`PCSEQ_ADDR_W:0]     char_addr,      // Character store addr.
   output logic                       char_rd,        // Character read strobe.
   output logic                       synth_enable,   // Synthesizer enable.
   output logic                       osd_enable,     // Display enable.
   output logic                       chip_reset      // Chip-enable reset pulse.
);
   localparam logic [CNT_W:0] PROG_LAST = `PCSEQ_PROG_LAST;

   pcseq_state_t      state;
   logic [CNT_W-1:0]  next_count;
   logic              next_seg;
   logic              ce_level;
   logic              ce_reset;
   logic [CNT_W:0]    fetch_addr;

   // Only the default layout is served: the page field and the system
   // call block encoding are fixed to a 13-bit counter.
   if (CNT_W != `PCSEQ_CNT_W || WORD_W != `PCSEQ_WORD_W) begin : g_bad_width
      $error("pcseq_sequencer: unsupported counter or word width");
   end

   pcseq_ce_edge u_ce (
      .clock     (clock),
      .rst       (rst),
      .level_in  (op_select),
      .align     (timer_carry),
      .enable    (ce_level),
      .reset_req (ce_reset)
   );

   // Next counter and segment for an executing instruction.
   always_comb begin
      next_count = pc_count;
      next_seg   = segment_select_bit;
      case (instr_op)
         PCSEQ_OP_SEQ: begin
            // The sum wraps in 13 bits, so segment never sees a carry.
            next_count = pc_count + 1'b1;
         end
         PCSEQ_OP_BR_DIRECT: begin
            next_count = {pc_count[`PCSEQ_PAGE_HI:`PCSEQ_PAGE_LO],
                          instr_addr[`PCSEQ_PAGE_LO-1:0]};
         end
         PCSEQ_OP_CALL_DIRECT: begin
            next_count = {2'h0, instr_addr[`PCSEQ_PAGE_LO-1:0]};
         end
         PCSEQ_OP_JUMP_INDIRECT: begin
            next_count = addr_reg[CNT_W-1:0];
            next_seg   = addr_reg[CNT_W];
         end
         PCSEQ_OP_SYSTEM_CALL_INSTRUCTION: begin
            // Block number lands on bits 10:8, entry offset on 3:0.
            next_count = {2'h0, system_call_instruction_entry[6:`PCSEQ_SYSTEM_CALL_INSTRUCTION_BLKLO], 4'h0,
                          system_call_instruction_entry[`PCSEQ_SYSTEM_CALL_INSTRUCTION_BLKLO-1:0]};
            next_seg   = `PCSEQ_SYSTEM_CALL_INSTRUCTION_SEG;
         end
         PCSEQ_OP_RETURN: begin
            next_count = return_addr[CNT_W-1:0];
            next_seg   = return_addr[CNT_W];
         end
         default: begin
            next_count = pc_count;
         end
      endcase
   end

   // Table read sequencing; the counter is frozen while it runs.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= PCSEQ_ST_RUN;
      end else if (ce_reset) begin
         state <= PCSEQ_ST_RUN;
      end else begin
         case (state)
            PCSEQ_ST_RUN: begin
               if (instr_valid && instr_op == PCSEQ_OP_TABLE)
                  state <= PCSEQ_ST_TABLE_FETCH;
            end
            PCSEQ_ST_TABLE_FETCH:   state <= PCSEQ_ST_TABLE_DELIVER;
            PCSEQ_ST_TABLE_DELIVER: state <= PCSEQ_ST_RUN;
            default:                state <= PCSEQ_ST_RUN;
         endcase
      end
   end

   // Program counter and segment select.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc_count           <= `PCSEQ_RESET_PC;
         segment_select_bit <= `PCSEQ_RESET_SEG;
      end else if (ce_reset) begin
         pc_count           <= `PCSEQ_RESET_PC;
         segment_select_bit <= `PCSEQ_RESET_SEG;
      end else if (state == PCSEQ_ST_RUN && instr_valid &&
                   instr_op != PCSEQ_OP_TABLE) begin
         pc_count           <= next_count;
         segment_select_bit <= next_seg;
      end else if (state == PCSEQ_ST_TABLE_DELIVER) begin
         pc_count <= pc_count + 1'b1;
      end
   end

   // Address driven to program memory: the counter, or the address
   // register during the table fetch.
   assign fetch_addr = (state == PCSEQ_ST_TABLE_FETCH) ? addr_reg :
                       {segment_select_bit, pc_count};

   // Program memory port; character area is never fetched as program.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prog_addr     <= '0;
         prog_rd       <= 1'b0;
         prog_addr_bad <= 1'b0;
         page          <= 2'h0;
      end else begin
         prog_addr     <= fetch_addr;
         prog_rd       <= (fetch_addr <= PROG_LAST);
         prog_addr_bad <= (fetch_addr > PROG_LAST);
         page          <= pc_count[`PCSEQ_PAGE_HI:`PCSEQ_PAGE_LO];
      end
   end

   // Whole-word capture of instructions and table constants.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         instr_word      <= '0;
         data_buffer     <= '0;
         data_buffer_vld <= 1'b0;
         busy            <= 1'b0;
      end else begin
         data_buffer_vld <= 1'b0;
         busy            <= (state != PCSEQ_ST_RUN);
         if (state == PCSEQ_ST_TABLE_DELIVER) begin
            data_buffer     <= prog_rdata;
            data_buffer_vld <= 1'b1;
         end else begin
            instr_word <= prog_rdata;
         end
      end
   end

   // Each 24-bit pattern spans two words of character storage, so the
   // video address offset is doubled onto the real range.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         char_addr <= '0;
         char_rd   <= 1'b0;
      end else begin
         char_addr <= {1'b0, `PCSEQ_CHAR_FIRST} +
                      {2'h0, video_pattern, 1'b0};
         char_rd   <= pattern_req &&
                      ((`PCSEQ_CHAR_FIRST | {2'h0, video_pattern}) <=
                       `PCSEQ_CHAR_VLAST);
      end
   end

   // Peripheral enables follow the operation-select level.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         synth_enable <= 1'b0;
         osd_enable   <= 1'b0;
         chip_reset   <= 1'b0;
      end else begin
         synth_enable <= ce_level;
         osd_enable   <= ce_level;
         chip_reset   <= ce_reset;
      end
   end
endmodule : pcseq_sequencer

//--- pcseq_sequencer_props.sv
// Assertions on the program counter sequencer ports.
module pcseq_sequencer_props
   import pcseq_pkg::*;
(
   input wire logic        clock,              // Clock.
   input wire logic        rst,                // Reset.
   input wire logic        op_select,          // Select level.
   input wire logic        instr_valid,        // Issue.
   input wire pcseq_op_t   instr_op,           // Operation.
   input wire logic [6:0]  system_call_instruction_entry,       // Entry.
   input wire logic [13:0] prog_addr,          // Fetch address.
   input wire logic        prog_rd,            // Read strobe.
   input wire logic        prog_addr_bad,      // Outside store.
   input wire logic        segment_select_bit, // Segment.
   input wire logic [12:0] pc_count,           // Counter.
   input wire logic        data_buffer_vld,    // Table word.
   input wire logic        busy,               // Frozen.
   input wire logic        synth_enable,       // Synthesizer.
   input wire logic        osd_enable,         // Display.
   input wire logic        chip_reset          // Reset pulse.
);
   // ==========================================================
   // Properties
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   logic        take;
   logic [12:0] target;
   // The bench never issues in the cycle before busy rises, so an idle
   // busy is a safe stand-in for the run state here.
   assign take = instr_valid && !busy;
   assign target = {2'h0, system_call_instruction_entry[6:4], 4'h0, system_call_instruction_entry[3:0]};
   seq_step_a: assert property (
      take && instr_op == PCSEQ_OP_SEQ |=> pc_count == $past(pc_count) + 1'b1
      && $stable(segment_select_bit)) else $error("counter step wrong");
   system_call_instruction_load_a: assert property (
      take && instr_op == PCSEQ_OP_SYSTEM_CALL_INSTRUCTION |=> segment_select_bit
      && pc_count == $past(target)) else $error("system call wrong");
   fetch_range_a: assert property (
      prog_rd |-> prog_addr <= 14'h2fff) else $error("read outside store");
   char_guard_a: assert property (
      prog_addr_bad == (prog_addr > 14'h2fff)) else $error("bad flag wrong");
   table_word_a: assert property (
      take && instr_op == PCSEQ_OP_TABLE |-> ##[2:4] data_buffer_vld)
      else $error("table word missing");
   table_hold_a: assert property (
      take && instr_op == PCSEQ_OP_TABLE |-> ##4
      pc_count == $past(pc_count, 4) + 1'b1) else $error("table count wrong");
   enable_track_a: assert property (
      !$past(rst) && !$past(rst, 2) |-> synth_enable == $past(op_select, 2)
      && osd_enable == synth_enable) else $error("enable lag wrong");
   ce_clear_a: assert property (
      $rose(chip_reset) |-> pc_count == 13'h0 && !segment_select_bit)
      else $error("chip reset left counter set");
endmodule : pcseq_sequencer_props

bind pcseq_sequencer pcseq_sequencer_props i_props (.clock(clock), .rst(rst),
   .op_select(op_select), .instr_valid(instr_valid), .instr_op(instr_op),
   .system_call_instruction_entry(system_call_instruction_entry), .prog_addr(prog_addr), .prog_rd(prog_rd),
   .prog_addr_bad(prog_addr_bad), .segment_select_bit(segment_select_bit),
   .pc_count(pc_count), .data_buffer_vld(data_buffer_vld), .busy(busy),
   .synth_enable(synth_enable), .osd_enable(osd_enable),
   .chip_reset(chip_reset));

//--- pcseq_prog_mem.sv
// Behavioural program memory answering the sequencer's fetch address.
module pcseq_prog_mem (
   input  wire logic [13:0] prog_addr,  // Fetch address.
   input  wire logic        prog_rd,    // Read strobe.
   output logic      [15:0] prog_rdata  // Word at the address.
);
   timeunit 1ns;
   timeprecision 1ps;
   // One whole word per address; with no strobe the bus shows the inverse,
   // so a stale word can never pass for a good one.
   always_comb begin
      prog_rdata = {prog_addr ^ 14'h2a5c, prog_addr[1:0]};
      if (!prog_rd) begin
         prog_rdata = ~prog_rdata;
      end
   end
endmodule : pcseq_prog_mem

//--- program_counter_sequencer_test.sv
// Self-checking bench for the program counter sequencer.
module program_counter_sequencer_test import pcseq_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals, design and memory
   logic        clock = 0, rst = 1, op_select = 0, timer_carry = 0;
   logic        instr_valid = 0, pattern_req = 0, prog_rd, vld;
   logic        seg, exp_seg = 0, char_rd, synth, osd, crst;
   logic        bad_flag, busy;
   pcseq_op_t   instr_op = PCSEQ_OP_SEQ;
   pcseq_op_t   ops[6] = '{PCSEQ_OP_SEQ, PCSEQ_OP_JUMP_INDIRECT,
                          PCSEQ_OP_SYSTEM_CALL_INSTRUCTION, PCSEQ_OP_RETURN,
                          PCSEQ_OP_BR_DIRECT, PCSEQ_OP_CALL_DIRECT};
   logic [12:0] instr_addr = 0, pc_count, exp_pc = 0;
   logic [6:0]  system_call_instruction_entry = 0;
   logic [13:0] addr_reg = 0, return_addr = 0, prog_addr;
   logic [11:0] video_pattern = 0;
   logic [15:0] prog_rdata, data_buffer, instr_word;
   logic [14:0] char_addr;
   logic [1:0]  page;
   int          bad_count = 0, n_tests = 0;
   pcseq_sequencer i_dut (.clock(clock), .rst(rst), .op_select(op_select),
      .timer_carry(timer_carry), .instr_valid(instr_valid),
      .instr_op(instr_op), .instr_addr(instr_addr),
      .system_call_instruction_entry(system_call_instruction_entry), .addr_reg(addr_reg),
      .return_addr(return_addr), .video_pattern(video_pattern),
      .pattern_req(pattern_req), .prog_rdata(prog_rdata),
      .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_addr_bad(bad_flag),
      .instr_word(instr_word), .page(page), .segment_select_bit(seg),
      .pc_count(pc_count), .data_buffer(data_buffer),
      .data_buffer_vld(vld), .busy(busy), .char_addr(char_addr),
      .char_rd(char_rd), .synth_enable(synth), .osd_enable(osd),
      .chip_reset(crst));
   pcseq_prog_mem i_mem (.prog_addr(prog_addr), .prog_rd(prog_rd),
      .prog_rdata(prog_rdata));
   // Clock at 250 MHz.
   always #2ns clock = ~clock;
   task automatic chk(input string what, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   function automatic logic [15:0] word_at(input logic [13:0] a);
      return {a ^ 14'h2a5c, a[1:0]};
   endfunction : word_at
   function automatic logic [12:0] sys_pc(input logic [6:0] e);
      return {2'h0, e[6:4], 4'h0, e[3:0]};
   endfunction : sys_pc
   // Outside the program store the memory shows the inverse word.
   function automatic logic [15:0] fetch_word(input logic [13:0] a);
      return (a <= 14'h2fff) ? word_at(a) : ~word_at(a);
   endfunction : fetch_word
   // Software aims only at defined words, skipping 1F00H to 1FFFH.
   function automatic logic [13:0] valid_addr();
      logic [13:0] a;
      a = 14'($urandom_range(14'h2eff));
      return (a >= 14'h1f00) ? a + 14'h0100 : a;
   endfunction : valid_addr
   // Each pattern takes two words, so the offset is doubled.
   function automatic logic [14:0] pat_addr(input logic [11:0] v);
      return 15'h3000 + {2'h0, v, 1'b0};
   endfunction : pat_addr
   function automatic logic pat_ok(input logic [11:0] v);
      return v <= 12'hfef;
   endfunction : pat_ok
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_of_test
   // A hang counts as a mismatch.
   initial begin
      #20us;
      bad_count++;
      end_of_test();
   end
   // Reset, random flow with a wrap first, table reads, select, patterns.
   initial begin
      void'($urandom(32'h53bf23e1));
      repeat (20) @(negedge clock);
      rst = 0;
      @(negedge clock);
      chk("reset address", {seg, pc_count}, 0);
      for (int i = 0; i < 300; i++) begin
         instr_valid = 1;
         instr_addr = 13'($urandom);
         // The wrap corner starts on the segment's last word on purpose.
         addr_reg = (i == 0) ? 14'h1fff : valid_addr();
         return_addr = valid_addr();
         system_call_instruction_entry = 7'($urandom);
         instr_op = (i < 2) ? ops[1 - i] : ops[$urandom_range(5)];
         case (instr_op)
            PCSEQ_OP_SEQ: exp_pc = exp_pc + 1'b1;
            PCSEQ_OP_BR_DIRECT: exp_pc = {exp_pc[12:11], instr_addr[10:0]};
            PCSEQ_OP_CALL_DIRECT: exp_pc = {2'h0, instr_addr[10:0]};
            PCSEQ_OP_SYSTEM_CALL_INSTRUCTION: {exp_seg, exp_pc} = {1'b1, sys_pc(system_call_instruction_entry)};
            PCSEQ_OP_RETURN: {exp_seg, exp_pc} = return_addr;
            default: {exp_seg, exp_pc} = addr_reg;
         endcase
         @(negedge clock);
         chk("counter", pc_count, exp_pc);
         chk("segment", seg, exp_seg);
      end
      instr_valid = 0;
      repeat (2) @(negedge clock);
      chk("page", page, exp_pc[12:11]);
      chk("instr", instr_word, fetch_word({exp_seg, exp_pc}));
      chk("bad flag", bad_flag, {exp_seg, exp_pc} > 14'h2fff);
      for (int i = 0; i < 8; i++) begin
         addr_reg = (i == 0) ? 14'h2fff : valid_addr();
         instr_op = PCSEQ_OP_TABLE;
         instr_valid = 1;
         @(negedge clock);
         instr_valid = 0;
         @(negedge clock);
         chk("busy", busy, 1);
         repeat (8) begin
            if (vld !== 1'b1) @(negedge clock);
         end
         chk("table word", data_buffer, word_at(addr_reg));
         @(negedge clock);
         exp_pc = exp_pc + 1'b1;
         chk("counter after table", pc_count, exp_pc);
      end
      op_select = 1;
      repeat (3) @(negedge clock);
      chk("synth on", synth, 1);
      chk("display on", osd, 1);
      chk("reset waits for carry", crst, 0);
      timer_carry = 1;
      @(negedge clock);
      timer_carry = 0;
      repeat (6) begin
         if (crst !== 1'b1) @(negedge clock);
      end
      chk("chip reset pulse", crst, 1);
      chk("chip reset address", {seg, pc_count}, 0);
      op_select = 0;
      repeat (3) @(negedge clock);
      chk("display off", osd, 0);
      for (int i = 0; i < 20; i++) begin
         video_pattern = (i < 2) ? 12'hfef + 12'(i) : 12'($urandom);
         pattern_req = (i != 3);
         repeat (2) @(negedge clock);
         chk("char addr", char_addr, pat_addr(video_pattern));
         chk("char rd", char_rd, pattern_req & pat_ok(video_pattern));
      end
      end_of_test();
   end
endmodule : program_counter_sequencer_test
